// ===== rtl/cprs_regset.sv
// Purpose: Processor register set with APB access and core-side ports
// Assumes: Core drives its strobes synchronous to pclk
// Notes:   APB answers with zero wait states
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module cprs_regset (
  // Clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Reset vector bytes and program counter control
  input  wire logic [7:0]                vec_lo_byte,
  input  wire logic [7:0]                vec_hi_byte,
  input  wire cprs_pkg::cprs_pc_op_t     pc_op,
  input  wire logic [2:0]                pc_inst_len,
  input  wire logic [19:0]               pc_target,
  // Flag and stack control
  input  wire cprs_pkg::cprs_flag_upd_t  flag_upd,
  input  wire cprs_pkg::cprs_stack_req_t stack_req,
  // Interrupt arbitration inputs
  input  wire logic                      irq_req,
  input  wire logic [1:0]                irq_prio,
  input  wire logic                      irq_ack,
  // General register access
  input  wire logic                      gpr_we,
  input  wire logic                      gpr_pair,
  input  wire logic [2:0]                gpr_idx,
  input  wire logic [15:0]               gpr_wdata,
  // Data address formation
  input  wire logic                      dacc_vld,
  input  wire logic                      dacc_seg_pfx,
  input  wire logic [15:0]               dacc_addr,
  // Outputs to the core
  output logic      [19:0]               next_instruction_address,
  output logic      [7:0]                processor_flag_word,
  output logic      [15:0]               stack_top_pointer,
  output logic      [15:0]               gpr_rdata,
  output logic      [19:0]               dacc_phys,
  output logic                           dacc_mirror,
  output logic                           cpu_stall,
  output logic                           irq_accept,
  output logic                           stack_range_err
);
  import cprs_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [19:0] nia_ff,     nxt_nia;
  logic [7:0]  pfw_ff,     nxt_pfw;
  logic [15:0] stp_ff,     nxt_stp;
  logic [3:0]  dseg_ff,    nxt_dseg;
  logic [3:0]  cseg_ff,    nxt_cseg;
  logic [7:0]  pmode_ff,   nxt_pmode;
  logic [3:0]  wait_ff,    nxt_wait;
  logic        vec_ld_ff;
  logic [7:0]  gpr_mem [0:31];
  logic [31:0] prdata_ff;
  logic [15:0] gpr_rd_ff;
  logic [19:0] phys_ff;
  logic        mirror_ff, stall_ff, acc_ff, serr_ff, stp_err_ff, pready_ff;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire        apb_acc   = psel & penable;
  wire        apb_wr    = apb_acc & pwrite;
  wire        sel_nia   = paddr == OFS_NIA;
  wire        sel_pfw   = paddr == OFS_PFW;
  wire        sel_stp   = paddr == OFS_STP;
  wire        sel_seg   = paddr == OFS_SEGEXT;
  wire        sel_pmode = paddr == OFS_PMODE;
  wire        sel_stat  = paddr == OFS_STATUS;
  wire        sel_gpr   = (paddr & GPR_MASK) == OFS_GPR && paddr[1:0] == 2'b00;
  wire        hit       = sel_nia | sel_pfw | sel_stp | sel_seg | sel_pmode | sel_stat | sel_gpr;
  wire [4:0]  apb_gidx  = paddr[6:2];

  // Bank 0 sits at the top: byte slot = (3 - bank) * 8 + register
  wire [1:0]  bank      = {pfw_ff[PFW_RB1], pfw_ff[PFW_RB0]};      // RULE_09
  wire [4:0]  gbase     = {~bank, 3'b000};                        // RULE_24 RULE_16
  wire [4:0]  g_lo      = gbase | {2'b00, gpr_idx[2:1], 1'b0};
  wire [4:0]  g_sel     = gpr_pair ? g_lo : (gbase | {2'b00, gpr_idx});  // RULE_17

  // ----------------------------------------------------------------
  // Next-instruction address
  // ----------------------------------------------------------------
  always_comb begin
    nxt_nia = nia_ff;
    if (vec_ld_ff) begin
      nxt_nia = {4'h0, vec_hi_byte, vec_lo_byte};                 // RULE_02
    end else if (cpu_stall) begin
      nxt_nia = nia_ff;                                           // RULE_21
    end else if (pc_op == CPRS_PC_BRANCH) begin
      nxt_nia = pc_target;                                        // RULE_03
    end else if (pc_op == CPRS_PC_SEQ) begin
      nxt_nia = nia_ff + {17'd0, pc_inst_len};                    // RULE_01
    end else if (apb_wr && sel_nia) begin
      nxt_nia = pwdata[19:0];
    end
  end

  // ----------------------------------------------------------------
  // Flag word
  // ----------------------------------------------------------------
  always_comb begin
    nxt_pfw = pfw_ff;
    if (apb_wr && sel_pfw) begin
      nxt_pfw = pwdata[7:0];
    end
    if (flag_upd.pfw_load) begin
      nxt_pfw = flag_upd.pfw_val;                                 // RULE_05
    end
    if (flag_upd.z_vld) begin
      nxt_pfw[PFW_Z] = flag_upd.z_res_zero;                       // RULE_08
    end
    if (flag_upd.hc_vld) begin
      nxt_pfw[PFW_HC] = flag_upd.hc_val;                          // RULE_10
    end
    if (flag_upd.cy_vld) begin
      nxt_pfw[PFW_CY] = flag_upd.cy_val;                          // RULE_12
    end
    if (flag_upd.bank_vld) begin
      nxt_pfw[PFW_RB1] = flag_upd.bank_val[1];                    // RULE_09
      nxt_pfw[PFW_RB0] = flag_upd.bank_val[0];
    end
    if (flag_upd.ie_set) begin
      nxt_pfw[PFW_IE] = 1'b1;                                     // RULE_06
    end
    // Acknowledge wins over an enable in the same cycle
    if (flag_upd.ie_clr || irq_ack) begin
      nxt_pfw[PFW_IE] = 1'b0;                                     // RULE_06
    end
  end

  // Lower priority number means more urgent; level 3 is the lowest
  wire [1:0] isp = {pfw_ff[PFW_IP1], pfw_ff[PFW_IP0]};
  // Only a strictly lower priority is held off; equal level still passes
  wire       prio_ok = irq_prio <= isp;                           // RULE_11
  wire       accept  = irq_req & pfw_ff[PFW_IE] & prio_ok;        // RULE_07

  // ----------------------------------------------------------------
  // Stack pointer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_stp = stp_ff;
    if (stack_req.load) begin
      nxt_stp = stack_req.load_val;
    end else if (stack_req.push) begin
      nxt_stp = stp_ff - {14'd0, stack_req.nbytes};               // RULE_14
    end else if (stack_req.pop) begin
      nxt_stp = stp_ff + {14'd0, stack_req.nbytes};               // RULE_14
    end else if (apb_wr && sel_stp) begin
      nxt_stp = pwdata[15:0];
    end
  end
  // Flags a stack outside internal RAM or inside the general registers
  // Judged on the next value so the flag can leave a flip-flop in step with the pointer
  wire nxt_stp_bad = nxt_stp < RAM_LO || nxt_stp > RAM_HI ||
                     {NEAR_TOP, nxt_stp} >= GPR_BASE;             // RULE_13 RULE_18

  // ----------------------------------------------------------------
  // Segment, mode and wait logic
  // ----------------------------------------------------------------
  assign nxt_dseg  = (apb_wr && sel_seg) ? pwdata[3:0] : dseg_ff;
  assign nxt_cseg  = (apb_wr && sel_seg) ? pwdata[11:8] : cseg_ff;
  // Mirror select stays writable and is acted on: pmode_ff[0] set holds dacc_mirror low
  assign nxt_pmode = (apb_wr && sel_pmode) ? pwdata[7:0] : pmode_ff;

  wire [19:0] phys = {dacc_seg_pfx ? dseg_ff : NEAR_TOP, dacc_addr};  // RULE_20
  wire        in_wait_win = dacc_vld && phys >= XSFR_WLO && phys <= XSFR_WHI;
  always_comb begin
    nxt_wait = wait_ff;
    if (wait_ff != 4'd0) begin
      nxt_wait = wait_ff - 4'd1;
    end else if (in_wait_win) begin
      nxt_wait = WAIT_CLKS;                                       // RULE_21
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nia_ff    <= 20'h00000;
      pfw_ff    <= PFW_RST;                                       // RULE_04
      stp_ff    <= 16'h0000;
      dseg_ff   <= DSEG_RST;                                      // RULE_19
      cseg_ff   <= CSEG_RST;                                      // RULE_19
      pmode_ff  <= PMODE_RST;
      wait_ff   <= 4'd0;
      vec_ld_ff <= 1'b1;
    end else begin
      nia_ff    <= nxt_nia;
      pfw_ff    <= nxt_pfw;
      stp_ff    <= nxt_stp;
      dseg_ff   <= nxt_dseg;
      cseg_ff   <= nxt_cseg;
      pmode_ff  <= nxt_pmode;
      wait_ff   <= nxt_wait;
      vec_ld_ff <= 1'b0;
    end
  end

  // General registers: core port wins over an APB write to the same byte
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_gpr
      wire core_lo = gpr_we && g_sel == 5'(gi);
      wire core_hi = gpr_we && gpr_pair && (g_lo | 5'd1) == 5'(gi);
      wire bus_wr  = apb_wr && sel_gpr && apb_gidx == 5'(gi);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          gpr_mem[gi] <= 8'h00;
        end else if (core_lo) begin
          gpr_mem[gi] <= gpr_wdata[7:0];                          // RULE_17
        end else if (core_hi) begin
          gpr_mem[gi] <= gpr_wdata[15:8];                         // RULE_17
        end else if (bus_wr) begin
          gpr_mem[gi] <= pwdata[7:0];                             // RULE_16
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read mux and registered outputs
  // ----------------------------------------------------------------
  wire [31:0] status_word = {24'd0, wait_ff, 1'b0, dacc_mirror, accept, stp_err_ff};
  wire [31:0] rd_mux =
    sel_nia   ? {12'd0, nia_ff} :
    sel_pfw   ? {24'd0, pfw_ff} :
    sel_stp   ? {16'd0, stp_ff} :
    sel_seg   ? {20'd0, cseg_ff, 4'd0, dseg_ff} :
    sel_pmode ? {24'd0, pmode_ff} :
    sel_stat  ? status_word :
    sel_gpr   ? {24'd0, gpr_mem[apb_gidx]} : 32'h0;
  wire [15:0] gpr_rd = gpr_pair ? {gpr_mem[g_lo | 5'd1], gpr_mem[g_lo]}
                                : {8'h00, gpr_mem[g_sel]};        // RULE_17

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0;
      serr_ff   <= 1'b0;
      gpr_rd_ff <= 16'h0;
      phys_ff   <= 20'h0;
      mirror_ff <= 1'b0;
      stall_ff  <= 1'b0;
      acc_ff    <= 1'b0;
      stp_err_ff <= 1'b1;
      pready_ff <= 1'b0;
    end else begin
      prdata_ff <= (psel && !penable && !pwrite) ? rd_mux : prdata_ff;
      serr_ff   <= psel && !penable && !hit;
      gpr_rd_ff <= gpr_rd;
      phys_ff   <= phys;
      mirror_ff <= dacc_vld && phys[19:16] == NEAR_TOP && !pmode_ff[0];  // RULE_23
      // Entry cycle plus every counted wait clock
      stall_ff  <= in_wait_win || wait_ff != 4'd0;                // RULE_21
      acc_ff    <= accept;
      stp_err_ff <= nxt_stp_bad;                                  // RULE_13
      pready_ff <= 1'b1;
    end
  end

  assign prdata                   = prdata_ff;
  assign pready                   = pready_ff;
  assign pslverr                  = serr_ff;
  assign next_instruction_address = nia_ff;
  assign processor_flag_word      = pfw_ff;
  assign stack_top_pointer        = stp_ff;
  assign gpr_rdata                = gpr_rd_ff;
  assign dacc_phys                = phys_ff;
  assign dacc_mirror              = mirror_ff;
  assign cpu_stall                = stall_ff;
  assign irq_accept               = acc_ff;
  assign stack_range_err          = stp_err_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pfw_reset_val: assert property ($rose(presetn) |-> pfw_ff == PFW_RST) // RULE_04
    else $error("flag word not at reset value");
  a_seq_advance: assert property (pc_op == CPRS_PC_SEQ && !vec_ld_ff && !cpu_stall
    |=> nia_ff == $past(nia_ff) + {17'd0, $past(pc_inst_len)}) // RULE_01
    else $error("address did not advance by length");
  a_branch_load: assert property (pc_op == CPRS_PC_BRANCH && !vec_ld_ff && !cpu_stall
    |=> nia_ff == $past(pc_target)) // RULE_03
    else $error("branch target not loaded");
  a_vec_top_clear: assert property (vec_ld_ff |=> nia_ff[19:16] == 4'h0) // RULE_02
    else $error("upper address bits not cleared");
  a_ie_ack_clear: assert property (irq_ack |=> !pfw_ff[PFW_IE]) // RULE_06
    else $error("enable not cleared on acknowledge");
  a_ie_refuse: assert property (!pfw_ff[PFW_IE] |=> !irq_accept) // RULE_07
    else $error("request accepted while disabled");
  a_isp_block: assert property (irq_prio > isp |=> !irq_accept) // RULE_11
    else $error("lower priority request accepted");
  a_zero_flag: assert property (flag_upd.z_vld && !flag_upd.pfw_load
    |=> pfw_ff[PFW_Z] == $past(flag_upd.z_res_zero)) // RULE_08
    else $error("zero flag wrong");
  a_stack_push: assert property (stack_req.push && !stack_req.load
    |=> stp_ff == $past(stp_ff) - {14'd0, $past(stack_req.nbytes)}) // RULE_14
    else $error("stack pointer not predecremented");
  a_wait_stall: assert property (in_wait_win && wait_ff == 4'd0 |=> cpu_stall [*3]) // RULE_21
    else $error("wait window did not stall");
  a_seg_reset: assert property ($rose(presetn) |-> dseg_ff == DSEG_RST && cseg_ff == CSEG_RST) // RULE_19
    else $error("segment extension reset wrong");

  c_branch:    cover property (pc_op == CPRS_PC_BRANCH ##1 pc_op == CPRS_PC_SEQ);
  c_irq_taken: cover property (irq_accept ##1 irq_ack);
  c_wait:      cover property (in_wait_win ##1 cpu_stall);
  c_push_pop:  cover property (stack_req.push ##[1:4] stack_req.pop);

endmodule : cprs_regset

// ===== rtl/cprs_pkg.sv
// Purpose: Constants and types for the cpu processor register set
// Assumes: 100 MHz pclk, APB slave with 32-bit data
// Notes:   Functional notes below list the block's behaviour
// Functional notes
// RULE_01: Next-instruction address is 20 bits, advances by instruction length.
// RULE_02: Reset loads low 16 address bits from vector bytes 0 and 1, top cleared.
// RULE_03: Branch loads address from immediate operand or register contents.
// RULE_04: Flag word is 8 bits, updated by execution, resets to 06h.
// RULE_05: Flag word is pushed on interrupt or push, restored by returns or pop.
// RULE_06: Interrupt enable cleared by disable or acknowledge, set by enable instruction.
// RULE_07: Enable clear refuses all maskable requests; otherwise priority and masks decide.
// RULE_08: Zero flag set on zero or equal result, cleared otherwise.
// RULE_09: Two-bit bank field picks one of four banks, written by bank select.
// RULE_10: Half-carry set on carry or borrow at bit 3, cleared otherwise.
// RULE_11: In-service priority blocks requests of lower priority; enable still gates.
// RULE_12: Carry records add/sub overflow, rotate shift-out, bit accumulator.
// RULE_13: Stack pointer is 16 bits; only internal RAM is a valid stack.
// RULE_14: Stack pointer decrements before stack writes, increments after stack reads.
// RULE_15: Software loads the stack pointer before any stack use.
// RULE_16: General registers sit at FFEE0h..FFEFFh, four banks of eight bytes.
// RULE_17: Registers read as bytes or as four 16-bit pairs.
// RULE_18: Software never fetches from nor stacks in the general register range.
// RULE_19: Data segment extension resets to 0Fh, code segment extension to 00h.
// RULE_20: Plain data addresses reach F0000h..FFFFFh; prefix extends to full space.
// RULE_21: Access to F0400h..F04FFh stalls the cpu by inserted wait clocks.
// RULE_22: Software keeps the mirror-select bit cleared.
// RULE_23: With mirror-select zero, F0000h..FFFFFh reads map to 00000h..0FFFFh.
// RULE_24: Banks go top-down: bank 0 at FFEF8h, bank 3 at FFEE0h.
package cprs_pkg;

  // ----------------------------------------------------------------
  // APB register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_NIA    = 12'h000;
  localparam logic [11:0] OFS_PFW    = 12'h004;
  localparam logic [11:0] OFS_STP    = 12'h008;
  localparam logic [11:0] OFS_SEGEXT = 12'h00c;
  localparam logic [11:0] OFS_PMODE  = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_GPR    = 12'h100;
  localparam logic [11:0] GPR_MASK   = 12'hf80;

  // ----------------------------------------------------------------
  // Reset values and fixed addresses
  // ----------------------------------------------------------------
  localparam logic [7:0]  PFW_RST     = 8'h06;
  localparam logic [3:0]  DSEG_RST    = 4'hf;
  localparam logic [3:0]  CSEG_RST    = 4'h0;
  localparam logic [7:0]  PMODE_RST   = 8'h00;
  localparam logic [19:0] VEC_LO_ADDR = 20'h00000;
  localparam logic [19:0] VEC_HI_ADDR = 20'h00001;
  localparam logic [19:0] GPR_BASE    = 20'hffee0;
  localparam logic [19:0] XSFR_WLO    = 20'hf0400;
  localparam logic [19:0] XSFR_WHI    = 20'hf04ff;
  localparam logic [3:0]  NEAR_TOP    = 4'hf;
  localparam logic [15:0] RAM_LO      = 16'he900;
  localparam logic [15:0] RAM_HI      = 16'hfeff;
  localparam logic [3:0]  WAIT_CLKS   = 4'd2;

  // ----------------------------------------------------------------
  // Flag word bit positions
  // ----------------------------------------------------------------
  localparam int PFW_IE  = 7;
  localparam int PFW_Z   = 6;
  localparam int PFW_RB1 = 5;
  localparam int PFW_HC  = 4;
  localparam int PFW_RB0 = 3;
  localparam int PFW_IP1 = 2;
  localparam int PFW_IP0 = 1;
  localparam int PFW_CY  = 0;

  // Program counter action from the execution logic
  typedef enum logic [1:0] {
    CPRS_PC_HOLD,
    CPRS_PC_SEQ,
    CPRS_PC_BRANCH
  } cprs_pc_op_t;

  // Flag updates from execution; each valid bit enables its flag
  typedef struct packed {
    logic       z_vld;
    logic       z_res_zero;
    logic       hc_vld;
    logic       hc_val;
    logic       cy_vld;
    logic       cy_val;
    logic       ie_set;
    logic       ie_clr;
    logic       bank_vld;
    logic [1:0] bank_val;
    logic       pfw_load;
    logic [7:0] pfw_val;
  } cprs_flag_upd_t;

  // Stack request: push decrements first, pop increments after
  typedef struct packed {
    logic        push;
    logic        pop;
    logic        load;
    logic [15:0] load_val;
    logic [1:0]  nbytes;
  } cprs_stack_req_t;

endpackage : cprs_pkg

// ===== verif/cprs_core_model.sv
// Purpose: Core-side partner that drives execution strobes into the register set
// Assumes: Each strobe lasts one pclk cycle and changes just after a rising edge
// Notes:   Pushes are dropped until the stack pointer has been loaded
`timescale 1ns/1ps
module cprs_core_model (
  // Clock
  input  wire logic                 pclk,
  // Reset vector and program counter
  output logic [7:0]                vec_lo_byte,
  output logic [7:0]                vec_hi_byte,
  output cprs_pkg::cprs_pc_op_t     pc_op,
  output logic [2:0]                pc_inst_len,
  output logic [19:0]               pc_target,
  // Flags, stack and interrupts
  output cprs_pkg::cprs_flag_upd_t  flag_upd,
  output cprs_pkg::cprs_stack_req_t stack_req,
  output logic                      irq_req,
  output logic [1:0]                irq_prio,
  output logic                      irq_ack,
  // General registers and data addressing
  output logic                      gpr_we,
  output logic                      gpr_pair,
  output logic [2:0]                gpr_idx,
  output logic [15:0]               gpr_wdata,
  output logic                      dacc_vld,
  output logic                      dacc_seg_pfx,
  output logic [15:0]               dacc_addr
);
  import cprs_pkg::*;
  logic sp_loaded;
  // Reset vector held in code flash
  assign vec_lo_byte = 8'h34;
  assign vec_hi_byte = 8'h12;
  initial begin
    sp_loaded = 1'b0;
    pc_op = CPRS_PC_HOLD;
    {pc_inst_len, pc_target} = '0;
    flag_upd = '0;
    stack_req = '0;
    {irq_req, irq_prio, irq_ack} = '0;
    {gpr_we, gpr_pair, gpr_idx, gpr_wdata} = '0;
    {dacc_vld, dacc_seg_pfx, dacc_addr} = '0;
  end
  task automatic pc_go(input cprs_pc_op_t op, input logic [2:0] len, input logic [19:0] t);
    @(posedge pclk);
    pc_op <= op;
    pc_inst_len <= len;
    pc_target <= t;
    @(posedge pclk);
    pc_op <= CPRS_PC_HOLD;
  endtask : pc_go
  task automatic fu(input cprs_flag_upd_t f);
    @(posedge pclk);
    flag_upd <= f;
    @(posedge pclk);
    flag_upd <= '0;
  endtask : fu
  task automatic st(input cprs_stack_req_t s);
    @(posedge pclk);
    if (s.load) sp_loaded = 1'b1;
    if (!sp_loaded) s.push = 1'b0;
    stack_req <= s;
    @(posedge pclk);
    stack_req <= '0;
  endtask : st
  task automatic irq_go(input logic r, input logic [1:0] p, input logic a);
    @(posedge pclk);
    {irq_req, irq_prio, irq_ack} <= {r, p, a};
    @(posedge pclk);
    {irq_req, irq_ack} <= 2'b00;
  endtask : irq_go
  task automatic gpr_go(input logic pr, input logic [2:0] i, input logic [15:0] d);
    @(posedge pclk);
    {gpr_we, gpr_pair, gpr_idx, gpr_wdata} <= {1'b1, pr, i, d};
    @(posedge pclk);
    gpr_we <= 1'b0;
  endtask : gpr_go
  task automatic dacc_go(input logic pfx, input logic [15:0] a);
    @(posedge pclk);
    {dacc_vld, dacc_seg_pfx, dacc_addr} <= {1'b1, pfx, a};
    @(posedge pclk);
    dacc_vld <= 1'b0;
  endtask : dacc_go
endmodule : cprs_core_model

// ===== verif/tb_cpu_processor_register_set.sv
// Purpose: Self-checking bench for the processor register set
// Assumes: APB slave answers with zero wait states; the bench still waits for pready
// Notes:   Core strobes come from the partner model
`timescale 1ns/1ps
module tb_cpu_processor_register_set;
  import cprs_pkg::*;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, seen;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, rdat;
  logic [7:0]      vec_lo_byte, vec_hi_byte, processor_flag_word, pfw;
  cprs_pc_op_t     pc_op;
  logic [2:0]      pc_inst_len, gpr_idx;
  logic [19:0]     pc_target, next_instruction_address, dacc_phys;
  cprs_flag_upd_t  flag_upd;
  cprs_stack_req_t stack_req;
  logic            irq_req, irq_ack, gpr_we, gpr_pair, dacc_vld, dacc_seg_pfx;
  logic            dacc_mirror, cpu_stall, irq_accept, stack_range_err;
  logic [1:0]      irq_prio;
  logic [15:0]     gpr_wdata, dacc_addr, stack_top_pointer, gpr_rdata;
  int              n_fail = 0, cmp_count = 0, cyc = 0;
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  cprs_regset dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .vec_lo_byte, .vec_hi_byte, .pc_op, .pc_inst_len, .pc_target,
    .flag_upd, .stack_req, .irq_req, .irq_prio, .irq_ack, .gpr_we, .gpr_pair, .gpr_idx,
    .gpr_wdata, .dacc_vld, .dacc_seg_pfx, .dacc_addr, .next_instruction_address,
    .processor_flag_word, .stack_top_pointer, .gpr_rdata, .dacc_phys, .dacc_mirror,
    .cpu_stall, .irq_accept, .stack_range_err);
  cprs_core_model core (.pclk, .vec_lo_byte, .vec_hi_byte, .pc_op, .pc_inst_len,
    .pc_target, .flag_upd, .stack_req, .irq_req, .irq_prio, .irq_ack, .gpr_we, .gpr_pair,
    .gpr_idx, .gpr_wdata, .dacc_vld, .dacc_seg_pfx, .dacc_addr);
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk(rdat, e);
  endtask : rd
  // Acceptance may land one or two edges after the request
  task automatic irq_chk(input logic [1:0] p, input logic e);
    core.irq_go(1'b1, p, 1'b0);
    #1 seen = irq_accept;
    @(posedge pclk);
    #1 chk(seen | irq_accept, e);
  endtask : irq_chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    #1 chk(next_instruction_address, 20'h01234);
    rd(OFS_PFW, 32'h06);
    rd(OFS_SEGEXT, 32'h0f);
    rd(OFS_PMODE, 32'h00);
    rd(12'h020, 32'h00);
    chk(rerr, 1'b1);
    core.pc_go(CPRS_PC_SEQ, 3'd3, '0);
    #1 chk(next_instruction_address, 20'h01237);
    core.pc_go(CPRS_PC_BRANCH, 3'd0, 20'hfffff);
    #1 chk(next_instruction_address, 20'hfffff);
    core.pc_go(CPRS_PC_SEQ, 3'd2, '0);
    #1 chk(next_instruction_address, 20'h00001);
    core.fu('{z_vld: 1'b1, z_res_zero: 1'b1, default: '0});
    #1 chk(processor_flag_word, 8'h46);
    core.fu('{z_vld: 1'b1, default: '0});
    #1 chk(processor_flag_word, 8'h06);
    core.fu('{hc_vld: 1'b1, hc_val: 1'b1, cy_vld: 1'b1, cy_val: 1'b1, default: '0});
    #1 chk(processor_flag_word, 8'h17);
    for (int b = 0; b < 4; b++) begin
      core.fu('{bank_vld: 1'b1, bank_val: b[1:0], default: '0});
      pfw = 8'h17 | {2'b00, b[1], 1'b0, b[0], 3'b000};
      #1 chk(processor_flag_word, pfw);
      core.gpr_go(1'b0, 3'd5, 16'h00a0 + 16'(b));
      rd(12'(OFS_GPR + 4 * ((3 - b) * 8 + 5)), 32'h0a0 + 32'(b));
    end
    core.gpr_go(1'b1, 3'd2, 16'h3344);
    @(posedge pclk);
    #1 chk(gpr_rdata, 16'h3344);
    rd(12'h108, 32'h44);
    rd(12'h10c, 32'h33);
    irq_chk(2'd0, 1'b0);
    core.fu('{ie_set: 1'b1, default: '0});
    #1 chk(processor_flag_word, 8'hbf);
    irq_chk(2'd3, 1'b1);
    irq_chk(2'd2, 1'b1);
    core.irq_go(1'b0, 2'd0, 1'b1);
    #1 chk(processor_flag_word, 8'h3f);
    core.fu('{pfw_load: 1'b1, pfw_val: 8'h82, default: '0});
    #1 chk(processor_flag_word, 8'h82);
    irq_chk(2'd2, 1'b0);
    irq_chk(2'd0, 1'b1);
    core.st('{load: 1'b1, load_val: 16'hfe00, default: '0});
    #1 chk({stack_range_err, stack_top_pointer}, {1'b0, 16'hfe00});
    core.st('{push: 1'b1, nbytes: 2'd2, default: '0});
    #1 chk(stack_top_pointer, 16'hfdfe);
    core.st('{pop: 1'b1, nbytes: 2'd2, default: '0});
    #1 chk(stack_top_pointer, 16'hfe00);
    core.st('{load: 1'b1, load_val: 16'h1000, default: '0});
    #1 chk(stack_range_err, 1'b1);
    apb(1'b1, OFS_STP, 32'h0000f000);
    rd(OFS_STP, 32'h0000f000);
    core.dacc_go(1'b0, 16'h1234);
    #1 chk({dacc_mirror, dacc_phys}, {1'b1, 20'hf1234});
    core.dacc_go(1'b1, 16'h1234);
    #1 chk(dacc_phys, 20'hf1234);
    apb(1'b1, OFS_PMODE, 32'h0);
    apb(1'b1, OFS_SEGEXT, 32'h2);
    core.dacc_go(1'b1, 16'h1234);
    #1 chk({dacc_mirror, dacc_phys}, {1'b0, 20'h21234});
    core.dacc_go(1'b0, 16'h04ff);
    for (int i = 0; i < 3; i++) begin
      #1 chk(cpu_stall, 1'b1);
      @(posedge pclk);
    end
    #1 chk(cpu_stall, 1'b0);
    core.dacc_go(1'b0, 16'h0500);
    #1 chk(cpu_stall, 1'b0);
    report_and_stop();
  end
endmodule : tb_cpu_processor_register_set
